// ==== cap_sense_params.svh ====
// Register offsets, field positions and reset values for the capacitive sense control
`ifndef CAP_SENSE_PARAMS_SVH
`define CAP_SENSE_PARAMS_SVH
`define ADDR_AUTOSCAN_FIRST_CHANNEL 8'h92
`define ADDR_TOUCH_CONTROL_STATUS   8'h9a
`define ADDR_TOUCH_TRIGGER_CONFIG   8'h9e
`define ADDR_TOUCH_RESULT_LOW       8'ha9
`define ADDR_TOUCH_RESULT_HIGH      8'haa
`define BIT_SENSE_ENABLE            7
`define BIT_PIN_WATCH_EVENT         6
`define BIT_CONVERSION_DONE         5
`define BIT_CONVERSION_BUSY         4
`define BIT_COMPARE_ENABLE          3
`define BIT_THRESHOLD_EXCEEDED      0
`define FIELD_TRIGGER_HI            6
`define FIELD_TRIGGER_LO            4
`define FIELD_AVERAGE_HI            2
`define FIELD_AVERAGE_LO            0
`define RESET_BYTE                  8'h00
`define RESET_CHANNEL               6'h00
`endif

// ==== cap_sense_pkg.sv ====
// Types shared by the capacitive sense control files
package cap_sense_pkg;
   typedef enum logic [2:0] {
      trig_software   = 3'b000,
      trig_timer0     = 3'b001,
      trig_timer2     = 3'b010,
      trig_timer1     = 3'b011,
      trig_timer3     = 3'b100,
      trig_reserved   = 3'b101,
      trig_continuous = 3'b110,
      trig_autoscan   = 3'b111
   } trigger_mode_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef struct packed {
      logic [3:0] timer_overflow; // Bit 0..3 = timer 0..3
   } trigger_in_s;
endpackage

// ==== sample_accumulator.sv ====
// Sums samples and divides by the configured count
`timescale 1ns/1ns
module sample_accumulator
   import cap_sense_pkg::*;
#(
   parameter int SAMPLE_W = 16
)(
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic                clear,
   input  wire logic                sample_valid,
   input  wire logic [SAMPLE_W-1:0] sample,
   input  wire logic [2:0]          average_code,
   output logic                     result_valid,
   output logic [SAMPLE_W-1:0]      result
);
   logic [SAMPLE_W+5:0] sum;
   logic [SAMPLE_W+5:0] next_sum;
   logic [6:0]          count;
   logic [6:0]          next_count;
   logic [6:0]          target;
   logic [2:0]          shift;
   logic [SAMPLE_W+5:0] total;
   logic                next_result_valid;
   logic [SAMPLE_W-1:0] next_result;

   always_comb begin
      unique case (average_code)
         3'h0:    begin target = 7'h01; shift = 3'h0; end
         3'h1:    begin target = 7'h04; shift = 3'h2; end
         3'h2:    begin target = 7'h08; shift = 3'h3; end
         3'h3:    begin target = 7'h10; shift = 3'h4; end
         3'h4:    begin target = 7'h20; shift = 3'h5; end
         3'h5:    begin target = 7'h40; shift = 3'h6; end
         // Reserved codes fall back to a single sample
         default: begin target = 7'h01; shift = 3'h0; end
      endcase
   end

   always_comb begin
      total             = sum + {6'h00, sample};
      next_sum          = sum;
      next_count        = count;
      next_result_valid = 1'b0;
      next_result       = result;
      if (clear) begin
         next_sum   = '0;
         next_count = 7'h00;
      end else if (sample_valid) begin
         if (count + 7'h01 >= target) begin
            next_result       = SAMPLE_W'(total >> shift);
            next_result_valid = 1'b1;
            next_sum          = '0;
            next_count        = 7'h00;
         end else begin
            next_sum   = total;
            next_count = count + 7'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sum          <= '0;
         count        <= 7'h00;
         result_valid <= 1'b0;
         result       <= '0;
      end else begin
         sum          <= next_sum;
         count        <= next_count;
         result_valid <= next_result_valid;
         result       <= next_result;
      end
   end
endmodule

// ==== scan_channel.sv ====
// Auto-scan channel stepping and mux channel register
`timescale 1ns/1ns
`include "cap_sense_params.svh"
module scan_channel
   import cap_sense_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       load,
   input  wire logic [5:0] load_value,
   input  wire logic       advance,
   input  wire logic [5:0] first_channel,
   input  wire logic [5:0] last_channel,
   output logic [5:0]      channel
);
   logic [5:0] next_channel;

   always_comb begin
      next_channel = channel;
      if (load) begin
         next_channel = load_value;
      end else if (advance) begin
         if (channel == last_channel) begin
            next_channel = first_channel;
         end else begin
            next_channel = channel + 6'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         channel <= `RESET_CHANNEL;
      end else begin
         channel <= next_channel;
      end
   end
endmodule

// ==== capacitive_sense_control.sv ====
// Capacitive sense control: registers, triggering, compare and scan
//
// How it works
// - Enable bit zero keeps converter off and low-power; one makes it ready.
// - Retry request from a pin monitor sets a flag; software writes zero to clear.
// - Finished conversion sets done flag; only software clears it.
// - Busy reads one during a conversion, zero otherwise.
// - Writing busy one starts only in modes 000, 110, 111; writing zero does nothing.
// - Compare enable gates comparing each result against the 16-bit threshold.
// - Result above threshold sets sticky flag, cleared only by software.
// - Trigger field picks timer 0, 2, 1 or 3 overflow; 101 is reserved.
// - Mode 110 runs conversions back to back after busy is written one.
// - Mode 111 scans channels continuously after busy is written one.
// - Average field picks 1, 4, 8, 16, 32 or 64 samples; 11x reserved.
// - Last 16-bit result held in read-only high and low byte registers.
// - Six-bit first channel field names where auto-scan begins.
// - In auto-scan a first-channel write also loads the mux channel.
// - Unused bits read zero and ignore writes.
// - Accumulated sum is divided by the sample count before storing.
// - Scan steps channel unless above threshold, wrapping after last channel.
// - After a threshold stop, no scan conversion until busy is written one.
`timescale 1ns/1ns
`include "cap_sense_params.svh"
module capacitive_sense_control
   import cap_sense_pkg::*;
#(
   parameter int SAMPLE_W = 16
)(
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire sfr_req_s            sfr_req,
   input  wire trigger_in_s         trigger_in,
   input  wire logic [5:0]          scan_last_channel,
   input  wire logic [7:0]          threshold_high_byte,
   input  wire logic [7:0]          threshold_low_byte,
   input  wire logic                pin_watch_retry,
   input  wire logic                sample_done,
   input  wire logic [SAMPLE_W-1:0] sample_count,
   output logic [7:0]               sfr_rdata,
   output logic                     sample_start,
   output logic [5:0]               channel_select,
   output logic                     sense_powered,
   output logic                     threshold_event
);
   //////////////////////////////////////////////////////////////////////////////
   // Register state
   logic       sense_enable;
   logic       pin_watch_event_flag;
   logic       conversion_done_flag;
   logic       conversion_busy;
   logic       threshold_compare_enable;
   logic       threshold_exceeded_flag;
   logic [2:0] trigger_source_select;
   logic [2:0] sample_average_count;
   logic [5:0] scan_first_channel;
   logic [7:0] result_high_byte;
   logic [7:0] result_low_byte;
   logic       scan_halted;
   logic       sample_taken;
   logic       next_sample_taken;
   logic       next_sense_enable;
   logic       next_pin_watch_event_flag;
   logic       next_conversion_done_flag;
   logic       next_conversion_busy;
   logic       next_threshold_compare_enable;
   logic       next_threshold_exceeded_flag;
   logic [2:0] next_trigger_source_select;
   logic [2:0] next_sample_average_count;
   logic [5:0] next_scan_first_channel;
   logic [7:0] next_result_high_byte;
   logic [7:0] next_result_low_byte;
   logic       next_scan_halted;
   logic [7:0] next_sfr_rdata;
   logic       next_sample_start;
   logic       next_threshold_event;

   logic                wr_ctrl;
   logic                wr_cfg;
   logic                wr_first;
   logic                busy_kick;
   logic                timer_trigger;
   logic                start_conv;
   logic                acc_valid;
   logic [SAMPLE_W-1:0] acc_result;
   logic                above;
   logic                autoscan;
   logic                repeat_mode;
   logic                scan_advance;
   logic [5:0]          mux_channel;
   trigger_mode_e       mode;

   //////////////////////////////////////////////////////////////////////////////
   // Decode and triggers
   assign mode     = trigger_mode_e'(trigger_source_select);
   assign wr_ctrl  = sfr_req.wr && sfr_req.addr == `ADDR_TOUCH_CONTROL_STATUS;
   assign wr_cfg   = sfr_req.wr && sfr_req.addr == `ADDR_TOUCH_TRIGGER_CONFIG;
   assign wr_first = sfr_req.wr && sfr_req.addr == `ADDR_AUTOSCAN_FIRST_CHANNEL;
   assign autoscan    = mode == trig_autoscan;
   assign repeat_mode = mode == trig_continuous || autoscan;
   assign above = threshold_compare_enable &&
                  acc_result > {threshold_high_byte, threshold_low_byte};

   // Software start: only the three software-started modes accept it
   assign busy_kick = wr_ctrl && sfr_req.wdata[`BIT_CONVERSION_BUSY] &&
                      (mode == trig_software || repeat_mode);

   always_comb begin
      unique case (mode)
         trig_timer0: timer_trigger = trigger_in.timer_overflow[0];
         trig_timer2: timer_trigger = trigger_in.timer_overflow[2];
         trig_timer1: timer_trigger = trigger_in.timer_overflow[1];
         trig_timer3: timer_trigger = trigger_in.timer_overflow[3];
         default:     timer_trigger = 1'b0;
      endcase
   end

   // A new start is only issued from idle, so a trigger during a conversion is dropped
   assign start_conv = sense_enable && !conversion_busy && (busy_kick || timer_trigger);
   assign scan_advance = acc_valid && autoscan && !above && !scan_halted;

   //////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_sense_enable             = sense_enable;
      next_pin_watch_event_flag     = pin_watch_event_flag;
      next_conversion_done_flag     = conversion_done_flag;
      next_conversion_busy          = conversion_busy;
      next_threshold_compare_enable = threshold_compare_enable;
      next_threshold_exceeded_flag  = threshold_exceeded_flag;
      next_trigger_source_select    = trigger_source_select;
      next_sample_average_count     = sample_average_count;
      next_scan_first_channel       = scan_first_channel;
      next_result_high_byte         = result_high_byte;
      next_result_low_byte          = result_low_byte;
      next_scan_halted              = scan_halted;
      next_sample_start             = 1'b0;
      next_threshold_event          = 1'b0;
      next_sample_taken             = sample_done && conversion_busy;

      if (wr_ctrl) begin
         next_sense_enable             = sfr_req.wdata[`BIT_SENSE_ENABLE];
         next_threshold_compare_enable = sfr_req.wdata[`BIT_COMPARE_ENABLE];
         next_pin_watch_event_flag     = sfr_req.wdata[`BIT_PIN_WATCH_EVENT];
         next_conversion_done_flag     = sfr_req.wdata[`BIT_CONVERSION_DONE];
         next_threshold_exceeded_flag  = threshold_exceeded_flag &
                                         sfr_req.wdata[`BIT_THRESHOLD_EXCEEDED];
      end
      if (wr_cfg) begin
         next_trigger_source_select = sfr_req.wdata[`FIELD_TRIGGER_HI:`FIELD_TRIGGER_LO];
         next_sample_average_count  = sfr_req.wdata[`FIELD_AVERAGE_HI:`FIELD_AVERAGE_LO];
      end
      if (wr_first) begin
         next_scan_first_channel = sfr_req.wdata[5:0];
      end
      if (busy_kick) begin
         next_scan_halted = 1'b0;
      end

      if (start_conv) begin
         next_conversion_busy = 1'b1;
         next_sample_start    = 1'b1;
      end else if (conversion_busy && sample_taken && !acc_valid) begin
         next_sample_start = 1'b1; // More samples for this result
      end

      if (acc_valid) begin
         next_result_high_byte = acc_result[15:8];
         next_result_low_byte  = acc_result[7:0];
         if (above) begin
            next_threshold_exceeded_flag = 1'b1;
            next_threshold_event         = 1'b1;
            if (autoscan) begin
               next_scan_halted = 1'b1;
            end
         end
         // Back-to-back modes keep busy set and relaunch unless halted or disabled
         if (repeat_mode && sense_enable && !(autoscan && (above || scan_halted))) begin
            next_sample_start = 1'b1;
         end else begin
            next_conversion_busy = 1'b0;
         end
         next_conversion_done_flag = 1'b1;
      end
      if (pin_watch_retry) begin
         next_pin_watch_event_flag = 1'b1;
      end
      if (!sense_enable) begin
         next_conversion_busy = 1'b0;
         next_sample_start    = 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      next_sfr_rdata = 8'h00;
      if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            `ADDR_TOUCH_CONTROL_STATUS:
               next_sfr_rdata = {next_sense_enable, next_pin_watch_event_flag,
                                 next_conversion_done_flag, next_conversion_busy,
                                 next_threshold_compare_enable, 2'b00,
                                 next_threshold_exceeded_flag};
            `ADDR_TOUCH_TRIGGER_CONFIG:
               next_sfr_rdata = {1'b0, next_trigger_source_select,
                                 1'b0, next_sample_average_count};
            `ADDR_AUTOSCAN_FIRST_CHANNEL: next_sfr_rdata = {2'b00, next_scan_first_channel};
            `ADDR_TOUCH_RESULT_HIGH:      next_sfr_rdata = next_result_high_byte;
            `ADDR_TOUCH_RESULT_LOW:       next_sfr_rdata = next_result_low_byte;
            default:                      next_sfr_rdata = 8'h00;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sense_enable             <= 1'b0;
         pin_watch_event_flag     <= 1'b0;
         conversion_done_flag     <= 1'b0;
         conversion_busy          <= 1'b0;
         threshold_compare_enable <= 1'b0;
         threshold_exceeded_flag  <= 1'b0;
         trigger_source_select    <= 3'h0;
         sample_average_count     <= 3'h0;
         scan_first_channel       <= `RESET_CHANNEL;
         result_high_byte         <= `RESET_BYTE;
         result_low_byte          <= `RESET_BYTE;
         scan_halted              <= 1'b0;
         sample_taken             <= 1'b0;
         sfr_rdata                <= `RESET_BYTE;
         sample_start             <= 1'b0;
         channel_select           <= `RESET_CHANNEL;
         sense_powered            <= 1'b0;
         threshold_event          <= 1'b0;
      end else begin
         sense_enable             <= next_sense_enable;
         pin_watch_event_flag     <= next_pin_watch_event_flag;
         conversion_done_flag     <= next_conversion_done_flag;
         conversion_busy          <= next_conversion_busy;
         threshold_compare_enable <= next_threshold_compare_enable;
         threshold_exceeded_flag  <= next_threshold_exceeded_flag;
         trigger_source_select    <= next_trigger_source_select;
         sample_average_count     <= next_sample_average_count;
         scan_first_channel       <= next_scan_first_channel;
         result_high_byte         <= next_result_high_byte;
         result_low_byte          <= next_result_low_byte;
         scan_halted              <= next_scan_halted;
         sample_taken             <= next_sample_taken;
         sfr_rdata                <= next_sfr_rdata;
         sample_start             <= next_sample_start;
         channel_select           <= mux_channel;
         sense_powered            <= next_sense_enable;
         threshold_event          <= next_threshold_event;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Leaf blocks
   sample_accumulator #(
      .SAMPLE_W     (SAMPLE_W)
   ) u_acc (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .clear        (!sense_enable || start_conv),
      .sample_valid (sample_done && conversion_busy),
      .sample       (sample_count),
      .average_code (sample_average_count),
      .result_valid (acc_valid),
      .result       (acc_result)
   );

   scan_channel u_scan (
      .mclk          (mclk),
      .rst_n         (rst_n),
      .load          (wr_first && autoscan),
      .load_value    (sfr_req.wdata[5:0]),
      .advance       (scan_advance),
      .first_channel (scan_first_channel),
      .last_channel  (scan_last_channel),
      .channel       (mux_channel)
   );
endmodule

// ==== capacitive_sense_control_assertions.sv ====
// Port checker for the capacitive sense control
`timescale 1ns/1ns
module capacitive_sense_control_assertions
   import cap_sense_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire sfr_req_s    sfr_req,
   input wire trigger_in_s trigger_in,
   input wire logic        sample_done,
   input wire logic [7:0]  sfr_rdata,
   input wire logic        sample_start,
   input wire logic [5:0]  channel_select,
   input wire logic        sense_powered,
   input wire logic        threshold_event
);
   logic       wr_ctrl;
   logic [7:0] start_hist;
   logic [7:0] next_start_hist;
   logic [7:0] done_hist;
   logic [7:0] next_done_hist;
   logic [7:0] chan_hist;
   logic [7:0] next_chan_hist;
   ////////////////////////////////////////////////////////////////////////////////
   // Eight-cycle cause windows keep the start, event and channel cause checks bounded
   always_comb begin
      wr_ctrl = sfr_req.wr && sfr_req.addr == 8'h9a;
      next_start_hist = {start_hist[6:0],
         (wr_ctrl && sfr_req.wdata[4]) || (|trigger_in.timer_overflow) || sample_done};
      next_done_hist = {done_hist[6:0], sample_done};
      next_chan_hist = {chan_hist[6:0], sfr_req.wr || sample_done};
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         start_hist <= 8'h00;
         done_hist  <= 8'h00;
         chan_hist  <= 8'h00;
      end else begin
         start_hist <= next_start_hist;
         done_hist  <= next_done_hist;
         chan_hist  <= next_chan_hist;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   idle_read_zero_a: assert property (!sfr_req.rd |=> sfr_rdata == 8'h00)
      else $error("idle read data");
   unmapped_read_a: assert property (sfr_req.rd && !(sfr_req.addr inside
      {8'h92, 8'h9a, 8'h9e, 8'ha9, 8'haa}) |=> sfr_rdata == 8'h00)
      else $error("unmapped read");
   first_chan_bits_a: assert property (sfr_req.rd && sfr_req.addr == 8'h92
      |=> sfr_rdata[7:6] == 2'b00) else $error("channel bits set");
   config_unused_a: assert property (sfr_req.rd && sfr_req.addr == 8'h9e
      |=> !sfr_rdata[7] && !sfr_rdata[3]) else $error("config bits set");
   control_unused_a: assert property (sfr_req.rd && sfr_req.addr == 8'h9a
      |=> sfr_rdata[2:1] == 2'b00) else $error("control bits set");
   power_on_a: assert property (wr_ctrl && sfr_req.wdata[7] |-> ##[1:2] sense_powered)
      else $error("not powered");
   power_off_a: assert property (wr_ctrl && !sfr_req.wdata[7] |-> ##[1:2] !sense_powered)
      else $error("still powered");
   power_cause_a: assert property ($changed(sense_powered)
      |-> $past(wr_ctrl) || $past(wr_ctrl, 2)) else $error("power change unasked");
   start_cause_a: assert property (sample_start |-> |start_hist)
      else $error("start uncaused");
   start_pulse_a: assert property (sample_start |=> !sample_start)
      else $error("start too long");
   event_cause_a: assert property (threshold_event |-> |done_hist)
      else $error("event uncaused");
   channel_cause_a: assert property ($changed(channel_select) |-> |chan_hist)
      else $error("channel moved");
endmodule

bind capacitive_sense_control capacitive_sense_control_assertions chk (
   .mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req), .trigger_in(trigger_in),
   .sample_done(sample_done), .sfr_rdata(sfr_rdata), .sample_start(sample_start),
   .channel_select(channel_select), .sense_powered(sense_powered),
   .threshold_event(threshold_event));

// ==== sense_engine_model.sv ====
// Behavioural model of the analog sense engine and its channel mux
`timescale 1ns/1ns
module sense_engine_model (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        sample_start,
   input  wire logic [5:0]  channel_select,
   input  wire logic [15:0] base,
   input  var  int          lat,
   output logic             sample_done,
   output logic [15:0]      sample_count
);
   int          wait_cnt;
   logic        parity;
   logic [15:0] value;
   // Channel in bits 13:8; odd samples 2 higher
   always @(posedge mclk) begin
      value = base + {2'b00, channel_select, 8'h00} + (parity ? 16'h0002 : 16'h0000);
      sample_done  <= 1'b0;
      sample_count <= ~sample_count; // Garbage outside done
      if (!rst_n) begin
         wait_cnt     <= 0;
         parity       <= 1'b0;
         sample_count <= 16'h0000;
      end else if (sample_start) begin
         wait_cnt <= lat;
      end else if (wait_cnt == 1) begin
         sample_done  <= 1'b1;
         sample_count <= value;
         parity       <= ~parity;
         wait_cnt     <= 0;
      end else if (wait_cnt > 1) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
endmodule

// ==== capacitive_sense_control_tb.sv ====
// Testbench for the capacitive sense control
`timescale 1ns/1ns
module capacitive_sense_control_tb;
   import cap_sense_pkg::*;
   logic        mclk, rst_n, pin_watch_retry, sample_done, sample_start;
   logic        sense_powered, threshold_event;
   sfr_req_s    sfr_req;
   trigger_in_s trigger_in;
   logic [5:0]  scan_last_channel, channel_select;
   logic [7:0]  threshold_high_byte, threshold_low_byte, sfr_rdata, d, h;
   logic [15:0] sample_count, base, e;
   logic [5:0]  chq[$];
   int          lat, mismatches, checks_done, starts, dones, events, n0;
   int          mt[8] = '{1, 4, 8, 16, 32, 64, 1, 1};
   int          tm[5] = '{0, 0, 2, 1, 3};
   int          sc[4] = '{2, 3, 4, 2};
   logic [7:0]  ra[6] = '{8'h92, 8'h9a, 8'h9e, 8'ha9, 8'haa, 8'h93};

   capacitive_sense_control uut (.mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req),
      .trigger_in(trigger_in), .scan_last_channel(scan_last_channel),
      .threshold_high_byte(threshold_high_byte), .threshold_low_byte(threshold_low_byte),
      .pin_watch_retry(pin_watch_retry), .sample_done(sample_done),
      .sample_count(sample_count), .sfr_rdata(sfr_rdata), .sample_start(sample_start),
      .channel_select(channel_select), .sense_powered(sense_powered),
      .threshold_event(threshold_event));
   sense_engine_model engine (.mclk(mclk), .rst_n(rst_n), .sample_start(sample_start),
      .channel_select(channel_select), .base(base), .lat(lat), .sample_done(sample_done),
      .sample_count(sample_count));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (sample_start) starts++;
      if (threshold_event) events++;
      if (sample_done) begin
         dones++;
         chq.push_back(channel_select);
      end
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge mclk) sfr_req = {2'b10, a, v};
      @(negedge mclk) sfr_req = '0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge mclk) sfr_req = {2'b01, a, 8'h00};
      @(negedge mclk) v = sfr_rdata;
      sfr_req = '0;
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk({8'h00, v}, {8'h00, exp});
   endtask
   task tick(input logic [3:0] t);
      @(negedge mclk) trigger_in.timer_overflow = t;
      @(negedge mclk) trigger_in = '0;
   endtask
   task wait_idle;
      logic [7:0] v;
      int         n;
      v = 8'h10;
      n = 0;
      while (v[4] !== 1'b0 && n < 500) begin
         rd(8'h9a, v);
         n++;
      end
      chk(16'(n < 500), 16'h0001);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Run takes under two thousand cycles
   initial begin
      #(40 * 20000);
      mismatches++;
      stop_test;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {mismatches, checks_done, starts, dones, events} = '0;
      sfr_req = '0;
      trigger_in = '0;
      pin_watch_retry = 1'b0;
      scan_last_channel = 6'h04;
      threshold_high_byte = 8'h12;
      threshold_low_byte = 8'hff;
      base = 16'h1234;
      lat = 3;
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      for (int i = 0; i < 6; i++) rchk(ra[i], 8'h00);
      chk(16'(sense_powered), 16'h0000);
      wr(8'h9e, 8'hff);
      rchk(8'h9e, 8'h77);
      wr(8'h9e, 8'h00);
      wr(8'h92, 8'hff);
      rchk(8'h92, 8'h3f);
      chk(16'(channel_select), 16'h0000);
      wr(8'haa, 8'hff);
      wr(8'ha9, 8'hff);
      rchk(8'haa, 8'h00);
      rchk(8'ha9, 8'h00);
      wr(8'h9a, 8'h10);
      repeat (8) @(negedge mclk);
      chk(16'(starts), 16'h0000);
      wr(8'h9a, 8'hee);
      rchk(8'h9a, 8'he8);
      chk(16'(sense_powered), 16'h0001);
      wr(8'h9a, 8'h80);
      rchk(8'h9a, 8'h80);
      chk(16'(starts), 16'h0000);
      @(negedge mclk) pin_watch_retry = 1'b1;
      @(negedge mclk) pin_watch_retry = 1'b0;
      rchk(8'h9a, 8'hc0);
      rchk(8'h9a, 8'hc0);
      wr(8'h9a, 8'h80);
      for (int c = 0; c < 8; c++) begin
         wr(8'h9e, 8'(c));
         e = (mt[c] == 1) ? base + (dones[0] ? 16'h0002 : 16'h0000) : base + 16'h0001;
         wr(8'h9a, 8'h90);
         wait_idle;
         rd(8'haa, h);
         rd(8'ha9, d);
         chk({h, d}, e);
         rchk(8'h9a, 8'ha0);
         wr(8'h9a, 8'h80);
      end
      for (int i = 1; i < 6; i++) begin
         wr(8'h9e, 8'(i << 4));
         n0 = starts;
         wr(8'h9a, 8'h90);
         tick((i == 5) ? 4'hf : ~(4'h1 << tm[i % 5]));
         repeat (8) @(negedge mclk);
         chk(16'(starts), 16'(n0));
         if (i < 5) begin
            tick(4'h1 << tm[i]);
            wait_idle;
            chk(16'(starts), 16'(n0 + 1));
         end
      end
      lat = 7;
      wr(8'h9e, 8'h60);
      n0 = starts;
      wr(8'h9a, 8'h90);
      repeat (60) @(negedge mclk);
      chk(16'(starts >= n0 + 4), 16'h0001);
      rchk(8'h9a, 8'hb0);
      wr(8'h9a, 8'h00);
      rd(8'h9a, d);
      chk(16'(d[4]), 16'h0000);
      lat = 1;
      base = 16'h1000;
      wr(8'h9e, 8'h70);
      wr(8'h9a, 8'h80);
      wr(8'h92, 8'h02);
      repeat (2) @(negedge mclk);
      chk(16'(channel_select), 16'h0002);
      chq.delete();
      wr(8'h9a, 8'h90);
      repeat (40) @(negedge mclk);
      wr(8'h9a, 8'h00);
      for (int k = 0; k < 4; k++) chk(16'(chq[k]), 16'(sc[k]));
      chk(16'(events), 16'h0000);
      wr(8'h9a, 8'h80);
      wr(8'h92, 8'h02);
      wr(8'h9a, 8'h98);
      repeat (30) @(negedge mclk);
      chk(16'(events), 16'h0001);
      chk(16'(channel_select), 16'h0003);
      rchk(8'h9a, 8'ha9);
      n0 = starts;
      repeat (30) @(negedge mclk);
      chk(16'(starts), 16'(n0));
      wr(8'h9a, 8'h89);
      rchk(8'h9a, 8'h89);
      wr(8'h9a, 8'h88);
      rchk(8'h9a, 8'h88);
      wr(8'h9a, 8'h98);
      repeat (30) @(negedge mclk);
      chk(16'(starts), 16'(n0 + 1));
      chk(16'(events), 16'h0002);
      stop_test;
   end
endmodule
